// file: hw/two_wire_pkg.sv
package two_wire_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DATA = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_ADDR = 8'h0C;
  localparam logic [7:0] A_IST = 8'h10;
  localparam logic [7:0] A_IEN = 8'h14;
  localparam logic [7:0] A_ICLR = 8'h18;
  // Control register bit positions
  localparam int C_FLAG = 7;
  localparam int C_ACK = 6;
  localparam int C_START = 5;
  localparam int C_STOP = 4;
  // Interrupt status bit positions
  localparam int I_JOB = 0;
  localparam int I_BERR = 1;
  // Status codes
  localparam logic [7:0] ST_ADDR_RD = 8'hA8;
  localparam logic [7:0] ST_ARB_RD = 8'hB0;
  localparam logic [7:0] ST_TX_ACK = 8'hB8;
  localparam logic [7:0] ST_TX_NACK = 8'hC0;
  localparam logic [7:0] ST_LAST_ACK = 8'hC8;
  localparam logic [7:0] ST_NONE = 8'hF8;
  localparam logic [7:0] ST_BERR = 8'h00;
  localparam logic [7:0] ST_M_START = 8'h08;
  localparam logic [7:0] ST_M_RSTART = 8'h10;
  localparam logic [7:0] ST_M_ACK = 8'h18;
  localparam logic [7:0] ST_M_NACK = 8'h20;
  // Reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [7:0] CODE_RST = 8'hF8;
  localparam logic [1:0] IEN_RST = 2'h0;
  // Master clock half period, time and cycles; bus response codes
  localparam int CLK_NS = 100;
  localparam int SCL_HALF_NS = 5000;
  localparam int HALF_CYC = SCL_HALF_NS / CLK_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic flag;
    logic ack_en;
    logic start_req;
    logic stop_req;
  } ctrl_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_ADDR = 4'b0001,
    S_AACK = 4'b0010,
    S_TX = 4'b0011,
    S_DACK = 4'b0100,
    S_WAIT = 4'b0101,
    M_START = 4'b0110,
    M_HOLD = 4'b0111,
    M_STOP = 4'b1000,
    M_RSTART = 4'b1001,
    M_BIT = 4'b1010
  } state_t;
endpackage

// file: hw/two_wire_slave_tx.sv
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module two_wire_slave_tx #(
  parameter int HALF = two_wire_pkg::HALF_CYC
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SCL,
  output logic O_SCL_OE,
  output logic O_SDA,
  output logic O_SDA_OE,
  output logic O_IRQ
);
  function automatic logic addr_ok(input logic [7:0] a);
    return a == two_wire_pkg::A_CTRL || a == two_wire_pkg::A_DATA ||
           a == two_wire_pkg::A_STAT || a == two_wire_pkg::A_ADDR ||
           a == two_wire_pkg::A_IST || a == two_wire_pkg::A_IEN ||
           a == two_wire_pkg::A_ICLR;
  endfunction

  two_wire_pkg::ctrl_t ctl_q, ctl_d;
  two_wire_pkg::state_t st_q, st_d;
  logic [7:0] sh_q, sh_d, dbuf_q, addr_q, code_q, code_d, wdata_q, awaddr_q, stat_rd;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] div_q, div_d;
  logic [1:0] ist_q, ist_d, ien_q, ev;
  logic ph_q, ph_d, sda_oe_q, sda_d, scl_oe_q, scl_d, ack_q, ack_d, last_q, last_d;
  logic arb_q, arb_d, rep_q, rep_d, set_flag, clr_stop, berr, go_q, bus_free_q;
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q, line_lo_q;
  logic aw_have_q, w_have_q, wstrb0_q, aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  wire wr_en = wr_fire & wstrb0_q;
  wire wr_ctrl = wr_en & (awaddr_q == two_wire_pkg::A_CTRL);
  wire flag_clr = wr_ctrl & wdata_q[two_wire_pkg::C_FLAG];
  wire aw_have_d = (aw_have_q & ~wr_fire) | (I_AWVALID & aw_rdy_q);
  wire w_have_d = (w_have_q & ~wr_fire) | (I_WVALID & w_rdy_q);
  wire rd_fire = I_ARVALID & ar_rdy_q;
  wire rvalid_d = rd_fire | (rvalid_q & ~I_RREADY);
  // Prescaler bits read as zero, so codes compare directly
  assign stat_rd = ctl_q.flag ? code_q : two_wire_pkg::ST_NONE;
  wire [7:0] rd_byte =
    (I_ARADDR == two_wire_pkg::A_CTRL) ? {ctl_q, 4'h0} :
    (I_ARADDR == two_wire_pkg::A_DATA) ? dbuf_q :
    (I_ARADDR == two_wire_pkg::A_STAT) ? stat_rd :
    (I_ARADDR == two_wire_pkg::A_ADDR) ? addr_q :
    (I_ARADDR == two_wire_pkg::A_IST) ? {6'h00, ist_q} :
    (I_ARADDR == two_wire_pkg::A_IEN) ? {6'h00, ien_q} : 8'h00;

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_rdy_q <= 1'b0;
      w_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= two_wire_pkg::RESP_OKAY;
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= two_wire_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_rdy_q <= ~aw_have_d;
      w_rdy_q <= ~w_have_d;
      ar_rdy_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      bvalid_q <= wr_fire | (bvalid_q & ~I_BREADY);
      if (I_AWVALID & aw_rdy_q) awaddr_q <= I_AWADDR;
      if (I_WVALID & w_rdy_q) begin
        wdata_q <= I_WDATA[7:0];
        wstrb0_q <= I_WSTRB[0];
      end
      if (wr_fire) bresp_q <= addr_ok(awaddr_q) ? two_wire_pkg::RESP_OKAY
                                                : two_wire_pkg::RESP_SLVERR;
      if (rd_fire) begin
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= addr_ok(I_ARADDR) ? two_wire_pkg::RESP_OKAY : two_wire_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, data, address and interrupt registers
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctrl) begin
      ctl_d.ack_en = wdata_q[two_wire_pkg::C_ACK];
      ctl_d.start_req = wdata_q[two_wire_pkg::C_START];
      ctl_d.stop_req = wdata_q[two_wire_pkg::C_STOP];
    end else if (clr_stop) begin
      ctl_d.stop_req = 1'b0;
    end
    // A hardware set in the clearing cycle wins
    ctl_d.flag = set_flag | (ctl_q.flag & ~flag_clr);
  end

  assign ev = {berr, set_flag};
  wire iclr = wr_en & (awaddr_q == two_wire_pkg::A_ICLR);
  assign ist_d = ev | (ist_q & ~(iclr ? wdata_q[1:0] : 2'h0));

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      ctl_q <= '0;
      go_q <= 1'b0;
      dbuf_q <= two_wire_pkg::DATA_RST;
      addr_q <= two_wire_pkg::ADDR_RST;
      ist_q <= 2'h0;
      ien_q <= two_wire_pkg::IEN_RST;
      O_IRQ <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      go_q <= flag_clr & ctl_q.flag;
      if (wr_en && awaddr_q == two_wire_pkg::A_DATA) dbuf_q <= wdata_q;
      if (wr_en && awaddr_q == two_wire_pkg::A_ADDR) addr_q <= wdata_q;
      if (wr_en && awaddr_q == two_wire_pkg::A_IEN) ien_q <= wdata_q[1:0];
      ist_q <= ist_d;
      O_IRQ <= |(ist_d & ien_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line synchronisers and condition detect
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      bus_free_q <= 1'b1;
      line_lo_q <= 1'b0;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {I_SCL, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {I_SDA, sda_m_q, sda_s_q};
      if (start_det) bus_free_q <= 1'b0;
      else if (stop_det) bus_free_q <= 1'b1;
      line_lo_q <= 1'b0;
    end
  end

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire frame_ev = start_det | stop_det;
  wire [7:0] in_byte = {sh_q[6:0], sda_s_q};
  wire match_rd = ctl_q.ack_en & (in_byte[7:1] == addr_q[7:1]) & in_byte[0];
  wire tx_code = code_q == two_wire_pkg::ST_ADDR_RD || code_q == two_wire_pkg::ST_ARB_RD ||
                 code_q == two_wire_pkg::ST_TX_ACK;
  wire div_done = div_q == 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state machine
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    div_d = div_done ? div_q : div_q - 8'h01;
    ph_d = ph_q;
    sda_d = sda_oe_q;
    scl_d = scl_oe_q;
    code_d = code_q;
    ack_d = ack_q;
    last_d = last_q;
    arb_d = arb_q;
    rep_d = rep_q;
    set_flag = 1'b0;
    clr_stop = 1'b0;
    berr = 1'b0;
    unique case (st_q)
      // Unaddressed: only a START matters, so a master clocking on reads ones
      two_wire_pkg::S_IDLE: begin
        if (start_det) begin
          st_d = two_wire_pkg::S_ADDR;
          cnt_d = 4'h0;
        end else if (ctl_q.start_req && bus_free_q && !ctl_q.flag) begin
          st_d = two_wire_pkg::M_START;
          sda_d = 1'b1;
          div_d = HALF[7:0];
          arb_d = 1'b0;
          rep_d = 1'b0;
        end
      end
      two_wire_pkg::S_ADDR: begin
        if (frame_ev && cnt_q != 4'h0) begin
          berr = 1'b1;
        end else if (stop_det) begin
          st_d = two_wire_pkg::S_IDLE;
        end else if (start_det) begin
          cnt_d = 4'h0;
        end else if (scl_rise) begin
          sh_d = in_byte;
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h7) st_d = match_rd ? two_wire_pkg::S_AACK : two_wire_pkg::S_IDLE;
        end
      end
      two_wire_pkg::S_AACK: begin
        if (frame_ev) begin
          berr = 1'b1;
        end else if (scl_fall && !sda_oe_q) begin
          sda_d = 1'b1;
        end else if (scl_fall) begin
          sda_d = 1'b0;
          scl_d = 1'b1;
          set_flag = 1'b1;
          code_d = arb_q ? two_wire_pkg::ST_ARB_RD : two_wire_pkg::ST_ADDR_RD;
          st_d = two_wire_pkg::S_WAIT;
        end
      end
      two_wire_pkg::S_TX: begin
        if (frame_ev) begin
          berr = 1'b1;
        end else if (scl_fall && cnt_q == 4'h7) begin
          st_d = two_wire_pkg::S_DACK;
          sda_d = 1'b0;
        end else if (scl_fall) begin
          cnt_d = cnt_q + 4'h1;
          sh_d = {sh_q[6:0], 1'b1};
          sda_d = ~sh_q[6];
        end
      end
      two_wire_pkg::S_DACK: begin
        if (frame_ev) begin
          berr = 1'b1;
        end else if (scl_rise) begin
          ack_d = ~sda_s_q;
        end else if (scl_fall) begin
          st_d = two_wire_pkg::S_WAIT;
          scl_d = 1'b1;
          set_flag = 1'b1;
          code_d = !ack_q ? two_wire_pkg::ST_TX_NACK :
                   last_q ? two_wire_pkg::ST_LAST_ACK : two_wire_pkg::ST_TX_ACK;
        end
      end
      two_wire_pkg::S_WAIT: begin
        if (go_q) begin
          scl_d = 1'b0;
          st_d = two_wire_pkg::S_IDLE;
          if (code_q == two_wire_pkg::ST_BERR) begin
            clr_stop = ctl_q.stop_req;
          end else if (tx_code) begin
            st_d = two_wire_pkg::S_TX;
            sh_d = dbuf_q;
            cnt_d = 4'h0;
            sda_d = ~dbuf_q[7];
            last_d = ~ctl_q.ack_en;
          end
        end
      end
      two_wire_pkg::M_START: begin
        if (div_done) begin
          scl_d = 1'b1;
          set_flag = 1'b1;
          code_d = rep_q ? two_wire_pkg::ST_M_RSTART : two_wire_pkg::ST_M_START;
          st_d = two_wire_pkg::M_HOLD;
        end
      end
      // Bus stays held low here, so no other master can step in
      two_wire_pkg::M_HOLD: begin
        if (go_q) begin
          div_d = HALF[7:0];
          scl_d = 1'b0;
          ph_d = 1'b0;
          if (ctl_q.stop_req) begin
            st_d = two_wire_pkg::M_STOP;
          end else if (ctl_q.start_req) begin
            st_d = two_wire_pkg::M_RSTART;
            sda_d = 1'b0;
          end else begin
            st_d = two_wire_pkg::M_BIT;
            scl_d = 1'b1;
            sh_d = dbuf_q;
            cnt_d = 4'h0;
            sda_d = ~dbuf_q[7];
          end
        end
      end
      two_wire_pkg::M_STOP, two_wire_pkg::M_RSTART: begin
        if (!scl_s_q) begin
          div_d = HALF[7:0];
        end else if (div_done) begin
          div_d = HALF[7:0];
          sda_d = st_q == two_wire_pkg::M_RSTART;
          rep_d = 1'b1;
          clr_stop = st_q == two_wire_pkg::M_STOP;
          st_d = (st_q == two_wire_pkg::M_STOP) ? two_wire_pkg::S_IDLE : two_wire_pkg::M_START;
        end
      end
      two_wire_pkg::M_BIT: begin
        if (!ph_q) begin
          if (div_done) begin
            scl_d = 1'b0;
            ph_d = 1'b1;
            div_d = HALF[7:0];
          end
        end else if (!scl_s_q) begin
          div_d = HALF[7:0]; // Another party stretching
        end else if (!div_done) begin
        end else if (cnt_q == 4'h8) begin
          ack_d = ~sda_s_q;
          scl_d = 1'b1;
          set_flag = 1'b1;
          code_d = sda_s_q ? two_wire_pkg::ST_M_NACK : two_wire_pkg::ST_M_ACK;
          st_d = two_wire_pkg::M_HOLD;
        end else if (!sda_oe_q && !sda_s_q) begin
          arb_d = 1'b1;
          sh_d = in_byte;
          cnt_d = cnt_q + 4'h1;
          st_d = (cnt_q == 4'h7) ? two_wire_pkg::S_IDLE : two_wire_pkg::S_ADDR;
        end else begin
          scl_d = 1'b1;
          ph_d = 1'b0;
          div_d = HALF[7:0];
          sh_d = in_byte;
          cnt_d = cnt_q + 4'h1;
          sda_d = (cnt_q == 4'h7) ? 1'b0 : ~sh_q[6];
        end
      end
      default: begin
        st_d = two_wire_pkg::S_IDLE;
      end
    endcase
    // Error releases both lines and sends no STOP
    if (berr) begin
      st_d = two_wire_pkg::S_WAIT;
      code_d = two_wire_pkg::ST_BERR;
      set_flag = 1'b1;
      sda_d = 1'b0;
      scl_d = 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      st_q <= two_wire_pkg::S_IDLE;
      {sh_q, cnt_q, div_q, ph_q} <= 21'h000000;
      {sda_oe_q, scl_oe_q, ack_q, last_q, arb_q, rep_q} <= 6'h00;
      code_q <= two_wire_pkg::CODE_RST;
    end else begin
      st_q <= st_d;
      {sh_q, cnt_q, div_q, ph_q} <= {sh_d, cnt_d, div_d, ph_d};
      {sda_oe_q, scl_oe_q, ack_q, last_q, arb_q, rep_q} <=
        {sda_d, scl_d, ack_d, last_d, arb_d, rep_d};
      code_q <= code_d;
    end
  end

  assign {O_AWREADY, O_WREADY, O_BVALID, O_BRESP} = {aw_rdy_q, w_rdy_q, bvalid_q, bresp_q};
  assign {O_ARREADY, O_RVALID, O_RDATA, O_RRESP} = {ar_rdy_q, rvalid_q, rdata_q, rresp_q};
  assign {O_SCL, O_SDA, O_SCL_OE, O_SDA_OE} = {line_lo_q, line_lo_q, scl_oe_q, sda_oe_q};

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  sequence s_enter_wait;
    $rose(ctl_q.flag) ##0 st_q == two_wire_pkg::S_WAIT;
  endsequence

  idle_status_a: assert property (!ctl_q.flag |-> stat_rd == 8'hF8)
    else $error("status not F8 while flag clear");
  stretch_low_a: assert property ((st_q == two_wire_pkg::S_WAIT && ctl_q.flag &&
    code_q != 8'h00) |-> O_SCL_OE)
    else $error("clock not stretched while flag set");
  addr_read_a: assert property ((s_enter_wait ##0 code_q == 8'hA8) |->
    $past(st_q) == two_wire_pkg::S_AACK && !arb_q)
    else $error("A8 posted without address phase");
  tx_ack_a: assert property ((s_enter_wait ##0 code_q == 8'hB8) |->
    $past(st_q) == two_wire_pkg::S_DACK && ack_q && !last_q)
    else $error("B8 posted without acked byte");
  tx_nack_a: assert property ((s_enter_wait ##0 $past(st_q) == two_wire_pkg::S_DACK &&
    !ack_q) |-> code_q == 8'hC0)
    else $error("NACK did not post C0");
  last_ack_a: assert property ((s_enter_wait ##0 $past(st_q) == two_wire_pkg::S_DACK &&
    ack_q && last_q) |-> code_q == 8'hC8)
    else $error("ACK on last byte did not post C8");
  load_last_a: assert property ((go_q && st_q == two_wire_pkg::S_WAIT && tx_code) |=>
    st_q == two_wire_pkg::S_TX && last_q == !ctl_q.ack_en ##1 cnt_q == 4'h0)
    else $error("byte load did not follow ack enable");
  bus_error_a: assert property (berr |=> ctl_q.flag && code_q == 8'h00 && !O_SCL_OE &&
    !O_SDA_OE && ist_q[1])
    else $error("bus error not flagged");
  recover_a: assert property ((go_q && code_q == 8'h00 && ctl_q.stop_req) |=>
    st_q == two_wire_pkg::S_IDLE && !ctl_q.stop_req && !O_SDA_OE)
    else $error("bus error recovery failed");
  unaddressed_a: assert property ((go_q && st_q == two_wire_pkg::S_WAIT && !tx_code) |=>
    st_q == two_wire_pkg::S_IDLE ##1 !O_SDA_OE)
    else $error("not returned to unaddressed slave");
  ignore_a: assert property (st_q == two_wire_pkg::S_IDLE |-> !O_SDA_OE)
    else $error("unaddressed slave drives data");
endmodule

// file: test/two_wire_master_model.sv
`timescale 1ns/1ns
module two_wire_master_model #(
  parameter int HC = 4
) (
  input wire logic i_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  task automatic half();
    repeat (HC) @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // One clock pulse; the slave may hold the line low, so wait it out
  task automatic pulse(output logic b);
    int n;
    n = 0;
    half();
    o_scl_oe <= 1'b0;
    @(posedge i_clk);
    while (!i_scl && n < 5000) begin
      @(posedge i_clk);
      n++;
    end
    half();
    b = i_sda;
    o_scl_oe <= 1'b1;
    half();
  endtask
  task automatic wbit(input logic v);
    logic s;
    o_sda_oe <= ~v;
    pulse(s);
  endtask
  task automatic rbit(output logic b);
    o_sda_oe <= 1'b0;
    pulse(b);
  endtask
  // Also serves as repeated start, keeping the bus between phases
  task automatic start();
    o_sda_oe <= 1'b0;
    half();
    o_scl_oe <= 1'b0;
    half();
    o_sda_oe <= 1'b1;
    half();
    o_scl_oe <= 1'b1;
    half();
  endtask
  task automatic stop();
    o_sda_oe <= 1'b1;
    half();
    o_scl_oe <= 1'b0;
    half();
    o_sda_oe <= 1'b0;
    half();
  endtask
  task automatic wbyte(input logic [7:0] v, output logic a);
    for (int i = 7; i >= 0; i--) begin
      wbit(v[i]);
    end
    rbit(a);
  endtask
  // Answer bit: 0 asks for more data, 1 ends the read
  task automatic rbyte(output logic [7:0] v, input logic a);
    for (int i = 7; i >= 0; i--) begin
      rbit(v[i]);
    end
    wbit(a);
  endtask
endmodule

// file: test/two_wire_slave_tx_tb.sv
`timescale 1ns/1ns
module two_wire_slave_tx_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata;
  logic scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe, scl, sda, ack;
  logic [7:0] rd, d;
  int n_mismatch = 0;
  int n_tests = 0;
  // Pulled-up lines: low while any party pulls
  assign scl = !((scl_oe && !scl_out) || m_scl_oe);
  assign sda = !((sda_oe && !sda_out) || m_sda_oe);
  initial begin
    forever #50 clk = ~clk;
  end
  two_wire_slave_tx #(.HALF(4)) i_dut (
    .I_CLOCK(clk), .I_RST_N(rst_n),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_SCL(scl), .I_SDA(sda), .O_SCL(scl_out), .O_SCL_OE(scl_oe),
    .O_SDA(sda_out), .O_SDA_OE(sda_oe), .O_IRQ(irq)
  );
  two_wire_master_model #(.HC(4)) m (
    .i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe)
  );
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
      n++;
    end while ((awvalid || wvalid || bready) && n < 100);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        v = rdata[7:0];
        rsp = rresp;
      end
      n++;
    end while (rready && n < 100);
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e, input string what);
    rd_reg(a, rd);
    check(what, rd, e);
  endtask
  // Polls until a code other than the idle one shows
  task automatic wait_code(input logic [7:0] e, input string what);
    int n;
    n = 0;
    do begin
      rd_reg(two_wire_pkg::A_STAT, rd);
      n++;
    end while ((rd & 8'hF8) === two_wire_pkg::ST_NONE && n < 80);
    check(what, rd & 8'hF8, e);
  endtask
  task automatic xfer(input logic [7:0] v, input logic [7:0] c, input logic a, input logic [7:0] e);
    wr(two_wire_pkg::A_DATA, v);
    wr(two_wire_pkg::A_CTRL, c);
    m.rbyte(d, a);
    check("byte out", d, v);
    wait_code(e, "after byte");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    expect_reg(two_wire_pkg::A_STAT, two_wire_pkg::CODE_RST, "stat rst");
    expect_reg(two_wire_pkg::A_ADDR, two_wire_pkg::ADDR_RST, "addr rst");
    expect_reg(two_wire_pkg::A_DATA, two_wire_pkg::DATA_RST, "data rst");
    expect_reg(two_wire_pkg::A_IEN, 8'h00, "ien rst");
    // Low byte strobe clear: the write must leave the buffer alone
    wstrb <= 4'hE;
    wr(two_wire_pkg::A_DATA, 8'h12);
    wstrb <= 4'hF;
    check("strobe off", {6'h00, bresp}, {6'h00, two_wire_pkg::RESP_OKAY});
    expect_reg(two_wire_pkg::A_DATA, two_wire_pkg::DATA_RST, "data kept");
    rd_reg(8'h1C, rd);
    check("unmapped", {6'h00, rsp}, {6'h00, two_wire_pkg::RESP_SLVERR});
    wr(two_wire_pkg::A_ADDR, 8'hB4);
    wr(two_wire_pkg::A_CTRL, 8'h40);
    // Write direction to own address is not answered here
    m.start();
    m.wbyte(8'hB4, ack);
    check("write dir", {7'h00, ack}, 8'h01);
    m.stop();
    m.start();
    m.wbyte(8'hB5, ack);
    check("addr ack", {7'h00, ack}, 8'h00);
    wait_code(two_wire_pkg::ST_ADDR_RD, "own read");
    check("irq masked", {7'h00, irq}, 8'h00);
    check("stretch", {7'h00, scl_oe}, 8'h01);
    wr(two_wire_pkg::A_IEN, 8'h01);
    repeat (2) @(posedge clk);
    check("irq on", {7'h00, irq}, 8'h01);
    wr(two_wire_pkg::A_ICLR, 8'h01);
    repeat (2) @(posedge clk);
    check("irq clr", {7'h00, irq}, 8'h00);
    xfer(8'hA5, 8'hC0, 1'b0, two_wire_pkg::ST_TX_ACK);
    xfer(8'h3C, 8'h80, 1'b0, two_wire_pkg::ST_LAST_ACK);
    wr(two_wire_pkg::A_CTRL, 8'hC0);
    m.rbyte(d, 1'b1);
    check("ones", d, 8'hFF);
    expect_reg(two_wire_pkg::A_STAT, two_wire_pkg::ST_NONE, "idle");
    m.stop();
    // Nack ending, then leave recognition off
    m.start();
    m.wbyte(8'hB5, ack);
    wait_code(two_wire_pkg::ST_ADDR_RD, "own read 2");
    xfer(8'h81, 8'hC0, 1'b1, two_wire_pkg::ST_TX_NACK);
    wr(two_wire_pkg::A_CTRL, 8'h80);
    m.stop();
    m.start();
    m.wbyte(8'hB5, ack);
    check("no recog", {7'h00, ack}, 8'h01);
    // Start queued while the bus is busy goes out once it frees
    wr(two_wire_pkg::A_CTRL, 8'h60);
    m.stop();
    wait_code(two_wire_pkg::ST_M_START, "queued start");
    wr(two_wire_pkg::A_CTRL, 8'hD0);
    repeat (40) @(posedge clk);
    expect_reg(two_wire_pkg::A_STAT, two_wire_pkg::ST_NONE, "after stop");
    // Start inside an address byte
    wr(two_wire_pkg::A_IEN, 8'h03);
    m.start();
    m.wbit(1'b1);
    m.wbit(1'b0);
    m.wbit(1'b1);
    m.start();
    wait_code(two_wire_pkg::ST_BERR, "bus error");
    rd_reg(two_wire_pkg::A_IST, rd);
    check("berr event", rd & 8'h02, 8'h02);
    check("berr irq", {7'h00, irq}, 8'h01);
    wr(two_wire_pkg::A_CTRL, 8'hD0);
    repeat (4) @(posedge clk);
    expect_reg(two_wire_pkg::A_STAT, two_wire_pkg::ST_NONE, "recovered");
    rd_reg(two_wire_pkg::A_CTRL, rd);
    check("stop cleared", rd & 8'h50, 8'h40);
    check("lines free", {6'h00, scl_oe, sda_oe}, 8'h00);
    wr(two_wire_pkg::A_ICLR, 8'h03);
    repeat (2) @(posedge clk);
    check("irq low", {7'h00, irq}, 8'h00);
    m.stop();
    final_report();
  end
endmodule
